/* hw/gio_consts.vh */
// Constants for the global I/O pin control block
`ifndef GIO_CONSTS_VH
`define GIO_CONSTS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define GIO_ADDR_ENABLE 32'hfff7f018
`define GIO_ADDR_DIR 32'hfff7f01c
`define GIO_ADDR_OPEN_DRAIN 32'hfff7f020
`define GIO_ADDR_LEVEL 32'hfff7f024
`define GIO_ADDR_READBACK 32'hfff7f028
`define GIO_ADDR_FUNC_SEL 32'hfff7f030

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define GIO_RST_WORD 32'h00000000
`define GIO_FSEL_W 10
`define GIO_FSEL_RST 10'h004
`define GIO_FSEL_MASK 10'h2f7

// ----------------------------------------------------------------
// Function select fields
// ----------------------------------------------------------------
`define GIO_FS_TPWM0 9
`define GIO_FS_CAPB_HI 7
`define GIO_FS_CAPB_LO 6
`define GIO_FS_CAPA_HI 5
`define GIO_FS_CAPA_LO 4
`define GIO_FS_JTAG_OFF 2
`define GIO_FS_RTC_IN 1
`define GIO_FS_RTC_OUT 0

// Capture route codes
`define GIO_CAP_OWN 2'h0
`define GIO_CAP_TDI 2'h1
`define GIO_CAP_TDO 2'h2
`define GIO_CAP_OTHER 2'h3

// ----------------------------------------------------------------
// Pin positions in the common bit map
// ----------------------------------------------------------------
`define GIO_PIN_TCK 27
`define GIO_PIN_TDO 26
`define GIO_PIN_TMS 25
`define GIO_PIN_TDI 24
`define GIO_PIN_CAPA 19
`define GIO_PIN_TPWM0 17
`define GIO_PIN_CAPB 16

// SPI lane order on the spi vectors
`define GIO_SPI_CLK 0
`define GIO_SPI_CS 1
`define GIO_SPI_MISO 2
`define GIO_SPI_MOSI 3

`endif

/* hw/gio_pin_cell.v */
// One digital I/O pin: ownership, open-drain and filtered readback
`timescale 1ns/10ps
module gio_pin_cell (
  input wire i_ref_clk,
  input wire i_arst_n,
  input wire i_global_en,
  input wire i_dir,
  input wire i_open_drain,
  input wire i_level,
  input wire i_func_out,
  input wire i_func_oe,
  input wire i_pin_in,
  output reg o_pin_out,
  output reg o_pin_oe,
  output reg o_level
);

  reg sync1;
  reg sync2;
  reg sync3;
  reg next_out;
  reg next_oe;

  // ----------------------------------------------------------------
  // Drive selection
  // ----------------------------------------------------------------
  // Pin owner decides drive; open drain steers level onto enable
  always @* begin
    if (!i_global_en) begin
      next_out = i_func_out;
      next_oe = i_func_oe;
    end else if (i_open_drain) begin
      next_out = 1'b0;
      next_oe = i_level;
    end else begin
      next_out = i_level;
      next_oe = i_dir;
    end
  end

  // Registered drive keeps glitches from muxing off the pad
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
    end else begin
      o_pin_out <= next_out;
      o_pin_oe <= next_oe;
    end
  end

  // ----------------------------------------------------------------
  // Input synchroniser and agreement filter
  // ----------------------------------------------------------------
  // Level only moves once the last two stages agree
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      o_level <= 1'b0;
    end else begin
      sync1 <= i_pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        o_level <= sync3;
      end
    end
  end

endmodule

/* hw/gio_pin_control.v */
// Global I/O pin control: registers, function routing and 32 pin cells
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`include "gio_consts.vh"
module gio_pin_control #(
  parameter PINS = 32
) (
  input wire i_ref_clk,
  input wire i_arst_n,
  // Register port
  input wire [31:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // Flash checksum verdict, valid from reset release
  input wire i_flash_checksum_ok,
  // Pads
  input wire [PINS-1:0] i_pin_in,
  output wire [PINS-1:0] o_pin_out,
  output wire [PINS-1:0] o_pin_oe,
  // Generic functional blocks, one lane per pin
  input wire [PINS-1:0] i_func_out,
  input wire [PINS-1:0] i_func_oe,
  output wire [PINS-1:0] o_func_in,
  // Timer PWM0 and sync sources
  input wire i_timer_pwm0,
  input wire i_sync_out,
  input wire i_sync_oe,
  // Timer capture inputs after routing
  output reg o_capture_a,
  output reg o_capture_b,
  // JTAG port
  input wire i_jtag_tdo,
  input wire i_jtag_tdo_oe,
  output reg o_jtag_tck,
  output reg o_jtag_tms,
  output reg o_jtag_tdi,
  // SPI port on the test pins: clk, cs, miso, mosi
  input wire [3:0] i_spi_out,
  input wire [3:0] i_spi_oe,
  output reg [3:0] o_spi_in,
  // Real-time clock
  input wire i_crystal_clock_input,
  input wire i_rtc_ref_clk,
  output reg o_rtc_clk_src,
  // Present JTAG-disable state
  output wire o_jtag_disabled
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [PINS-1:0] global_io_enable;
  reg [PINS-1:0] global_io_direction;
  reg [PINS-1:0] global_io_open_drain;
  reg [PINS-1:0] global_io_output_level;
  reg [`GIO_FSEL_W-1:0] pin_function_select;
  reg checksum_seen;
  reg [31:0] next_rdata;
  reg [PINS-1:0] route_out;
  reg [PINS-1:0] route_oe;
  reg crystal_s1;
  reg crystal_s2;
  reg crystal_s3;
  reg crystal_level;
  wire [PINS-1:0] pin_level;
  wire [PINS-1:0] global_io_pin_readback;
  wire jtag_off;
  wire [1:0] capture_a_pin_route;
  wire [1:0] capture_b_pin_route;
  wire timer_pwm0_pin_route;
  wire wr_enable;
  wire wr_dir;
  wire wr_od;
  wire wr_level;
  wire wr_fsel;

  // Field views of the function select register
  assign jtag_off = pin_function_select[`GIO_FS_JTAG_OFF];
  assign capture_a_pin_route =
    pin_function_select[`GIO_FS_CAPA_HI:`GIO_FS_CAPA_LO];
  assign capture_b_pin_route =
    pin_function_select[`GIO_FS_CAPB_HI:`GIO_FS_CAPB_LO];
  assign timer_pwm0_pin_route = pin_function_select[`GIO_FS_TPWM0];
  assign o_jtag_disabled = jtag_off;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_enable = i_wr && (i_addr == `GIO_ADDR_ENABLE);
  assign wr_dir = i_wr && (i_addr == `GIO_ADDR_DIR);
  assign wr_od = i_wr && (i_addr == `GIO_ADDR_OPEN_DRAIN);
  assign wr_level = i_wr && (i_addr == `GIO_ADDR_LEVEL);
  assign wr_fsel = i_wr && (i_addr == `GIO_ADDR_FUNC_SEL);

  // Per-pin control words, all on one bit map
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      global_io_enable <= `GIO_RST_WORD;
      global_io_direction <= `GIO_RST_WORD;
      global_io_open_drain <= `GIO_RST_WORD;
      global_io_output_level <= `GIO_RST_WORD;
    end else begin
      if (wr_enable) begin
        global_io_enable <= i_wdata[PINS-1:0];
      end
      if (wr_dir) begin
        global_io_direction <= i_wdata[PINS-1:0];
      end
      if (wr_od) begin
        global_io_open_drain <= i_wdata[PINS-1:0];
      end
      if (wr_level) begin
        global_io_output_level <= i_wdata[PINS-1:0];
      end
    end
  end

  // Function select: JTAG-disable comes out of reset set, then one
  // clocked look at the checksum clears it when the flash is bad.
  // A software write in that same first cycle wins over the verdict.
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_function_select <= `GIO_FSEL_RST;
      checksum_seen <= 1'b0;
    end else begin
      checksum_seen <= 1'b1;
      if (wr_fsel) begin
        // Reserved bits masked out on write
        pin_function_select <=
          i_wdata[`GIO_FSEL_W-1:0] & `GIO_FSEL_MASK;
      end else if (!checksum_seen && !i_flash_checksum_ok) begin
        pin_function_select[`GIO_FS_JTAG_OFF] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Readback is the filtered pad level seen after the muxing
  assign global_io_pin_readback = pin_level;

  always @* begin
    next_rdata = 32'h00000000;
    case (i_addr)
      `GIO_ADDR_ENABLE: next_rdata[PINS-1:0] = global_io_enable;
      `GIO_ADDR_DIR: next_rdata[PINS-1:0] = global_io_direction;
      `GIO_ADDR_OPEN_DRAIN: next_rdata[PINS-1:0] = global_io_open_drain;
      `GIO_ADDR_LEVEL: next_rdata[PINS-1:0] = global_io_output_level;
      `GIO_ADDR_READBACK: next_rdata[PINS-1:0] = global_io_pin_readback;
      `GIO_ADDR_FUNC_SEL:
        next_rdata[`GIO_FSEL_W-1:0] =
          pin_function_select & `GIO_FSEL_MASK;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Functional drive routing onto pins
  // ----------------------------------------------------------------
  // Start from the generic lanes, then let the routed functions take
  // their pins. Conflicting selections are software's fault and the
  // later assignment here simply wins.
  always @* begin
    route_out = i_func_out;
    route_oe = i_func_oe;
    // Timer PWM0 pin carries PWM0 or sync
    if (timer_pwm0_pin_route) begin
      route_out[`GIO_PIN_TPWM0] = i_sync_out;
      route_oe[`GIO_PIN_TPWM0] = i_sync_oe;
    end else begin
      route_out[`GIO_PIN_TPWM0] = i_timer_pwm0;
      route_oe[`GIO_PIN_TPWM0] = 1'b1;
    end
    // Test port: JTAG owns only TDO as an output
    if (jtag_off) begin
      route_out[`GIO_PIN_TCK] = i_spi_out[`GIO_SPI_CLK];
      route_oe[`GIO_PIN_TCK] = i_spi_oe[`GIO_SPI_CLK];
      route_out[`GIO_PIN_TMS] = i_spi_out[`GIO_SPI_CS];
      route_oe[`GIO_PIN_TMS] = i_spi_oe[`GIO_SPI_CS];
      route_out[`GIO_PIN_TDI] = i_spi_out[`GIO_SPI_MISO];
      route_oe[`GIO_PIN_TDI] = i_spi_oe[`GIO_SPI_MISO];
      route_out[`GIO_PIN_TDO] = i_spi_out[`GIO_SPI_MOSI];
      route_oe[`GIO_PIN_TDO] = i_spi_oe[`GIO_SPI_MOSI];
    end else begin
      route_out[`GIO_PIN_TCK] = 1'b0;
      route_oe[`GIO_PIN_TCK] = 1'b0;
      route_out[`GIO_PIN_TMS] = 1'b0;
      route_oe[`GIO_PIN_TMS] = 1'b0;
      route_out[`GIO_PIN_TDI] = 1'b0;
      route_oe[`GIO_PIN_TDI] = 1'b0;
      route_out[`GIO_PIN_TDO] = i_jtag_tdo;
      route_oe[`GIO_PIN_TDO] = i_jtag_tdo_oe;
    end
    // RTC reference clock out takes the TCK pin
    if (pin_function_select[`GIO_FS_RTC_OUT]) begin
      route_out[`GIO_PIN_TCK] = i_rtc_ref_clk;
      route_oe[`GIO_PIN_TCK] = 1'b1;
    end
    // TDI and TDO pins used by capture routing are inputs only
    if (capture_a_pin_route == `GIO_CAP_TDI ||
        capture_b_pin_route == `GIO_CAP_TDI) begin
      route_oe[`GIO_PIN_TDI] = 1'b0;
    end
    if (capture_a_pin_route == `GIO_CAP_TDO ||
        capture_b_pin_route == `GIO_CAP_TDO) begin
      route_oe[`GIO_PIN_TDO] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < PINS; gp = gp + 1) begin : g_pin
      gio_pin_cell u_cell (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_global_en(global_io_enable[gp]),
        .i_dir(global_io_direction[gp]),
        .i_open_drain(global_io_open_drain[gp]),
        .i_level(global_io_output_level[gp]),
        .i_func_out(route_out[gp]),
        .i_func_oe(route_oe[gp]),
        .i_pin_in(i_pin_in[gp]),
        .o_pin_out(o_pin_out[gp]),
        .o_pin_oe(o_pin_oe[gp]),
        .o_level(pin_level[gp])
      );
    end
  endgenerate

  // Generic lanes see the filtered pad levels
  assign o_func_in = pin_level;

  // ----------------------------------------------------------------
  // Crystal clock sampled into this domain
  // ----------------------------------------------------------------
  // Slow crystal only; a sampled copy is good enough for the RTC tick
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      crystal_s1 <= 1'b0;
      crystal_s2 <= 1'b0;
      crystal_s3 <= 1'b0;
      crystal_level <= 1'b0;
    end else begin
      crystal_s1 <= i_crystal_clock_input;
      crystal_s2 <= crystal_s1;
      crystal_s3 <= crystal_s2;
      if (crystal_s2 == crystal_s3) begin
        crystal_level <= crystal_s3;
      end
    end
  end

  // ----------------------------------------------------------------
  // Functional inputs from pins
  // ----------------------------------------------------------------
  // Registered so every function input is a flip-flop output
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_capture_a <= 1'b0;
      o_capture_b <= 1'b0;
      o_jtag_tck <= 1'b0;
      o_jtag_tms <= 1'b1;
      o_jtag_tdi <= 1'b0;
      o_spi_in <= 4'h0;
      o_rtc_clk_src <= 1'b0;
    end else begin
      case (capture_a_pin_route)
        `GIO_CAP_TDI: o_capture_a <= pin_level[`GIO_PIN_TDI];
        `GIO_CAP_TDO: o_capture_a <= pin_level[`GIO_PIN_TDO];
        `GIO_CAP_OTHER: o_capture_a <= pin_level[`GIO_PIN_CAPB];
        default: o_capture_a <= pin_level[`GIO_PIN_CAPA];
      endcase
      case (capture_b_pin_route)
        `GIO_CAP_TDI: o_capture_b <= pin_level[`GIO_PIN_TDI];
        `GIO_CAP_TDO: o_capture_b <= pin_level[`GIO_PIN_TDO];
        `GIO_CAP_OTHER: o_capture_b <= pin_level[`GIO_PIN_CAPA];
        default: o_capture_b <= pin_level[`GIO_PIN_CAPB];
      endcase
      // Disabled JTAG is parked in reset-safe idle levels
      if (jtag_off) begin
        o_jtag_tck <= 1'b0;
        o_jtag_tms <= 1'b1;
        o_jtag_tdi <= 1'b0;
        o_spi_in[`GIO_SPI_CLK] <= pin_level[`GIO_PIN_TCK];
        o_spi_in[`GIO_SPI_CS] <= pin_level[`GIO_PIN_TMS];
        o_spi_in[`GIO_SPI_MISO] <= pin_level[`GIO_PIN_TDI];
        o_spi_in[`GIO_SPI_MOSI] <= pin_level[`GIO_PIN_TDO];
      end else begin
        o_jtag_tck <= pin_level[`GIO_PIN_TCK];
        o_jtag_tms <= pin_level[`GIO_PIN_TMS];
        o_jtag_tdi <= pin_level[`GIO_PIN_TDI];
        o_spi_in <= 4'h0;
      end
      // RTC source: crystal or TCK pin
      if (pin_function_select[`GIO_FS_RTC_IN]) begin
        o_rtc_clk_src <= pin_level[`GIO_PIN_TCK];
      end else begin
        o_rtc_clk_src <= crystal_level;
      end
    end
  end

endmodule

/* bench/gio_pin_control_chk.sv */
// Checker for the global I/O pin control block
`timescale 1ns/10ps
`include "gio_consts.vh"
module gio_pin_control_chk #(
  parameter PINS = 32
) (
  input wire i_ref_clk,
  input wire i_arst_n,
  input wire [31:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire i_flash_checksum_ok,
  input wire [PINS-1:0] o_pin_out,
  input wire [PINS-1:0] o_pin_oe,
  input wire i_timer_pwm0,
  input wire i_sync_out,
  input wire i_sync_oe,
  input wire o_jtag_tck,
  input wire o_jtag_tms,
  input wire o_jtag_tdi,
  input wire [3:0] o_spi_in,
  input wire i_rtc_ref_clk,
  input wire o_jtag_disabled
);
  reg [31:0] en, dir, od, lvl, rd_exp;
  reg [9:0] fs;
  reg [1:0] age;
  wire [31:0] exp_oe = (od & lvl) | (~od & dir);
  // Shadow registers rebuilt from bus writes; age masks the reset edges
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {en, dir, od, lvl} <= 128'h0;
      fs <= `GIO_FSEL_RST;
      age <= 2'h0;
    end else begin
      age <= age + {1'b0, ~age[1]};
      if (i_wr && i_addr == `GIO_ADDR_ENABLE) en <= i_wdata;
      if (i_wr && i_addr == `GIO_ADDR_DIR) dir <= i_wdata;
      if (i_wr && i_addr == `GIO_ADDR_OPEN_DRAIN) od <= i_wdata;
      if (i_wr && i_addr == `GIO_ADDR_LEVEL) lvl <= i_wdata;
      if (i_wr && i_addr == `GIO_ADDR_FUNC_SEL)
        fs <= i_wdata[9:0] & `GIO_FSEL_MASK;
      else if (age == 2'h0 && !i_flash_checksum_ok)
        fs[2] <= 1'b0;
    end
  end
  // Expected read value; pad readback is judged by the bench instead
  always @* begin
    case (i_addr)
      `GIO_ADDR_ENABLE: rd_exp = en;
      `GIO_ADDR_DIR: rd_exp = dir;
      `GIO_ADDR_OPEN_DRAIN: rd_exp = od;
      `GIO_ADDR_LEVEL: rd_exp = lvl;
      `GIO_ADDR_FUNC_SEL: rd_exp = {22'h0, fs};
      default: rd_exp = 32'h0;
    endcase
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_js_on2;
    o_jtag_disabled [*2];
  endsequence
  sequence s_js_off2;
    !o_jtag_disabled [*2];
  endsequence
  a_read_idle: assert property (
    !i_rd |=> o_rdata == 32'h0) else $error("read data not idle");
  a_read_data: assert property (
    i_rd && i_addr != `GIO_ADDR_READBACK |=> o_rdata == $past(rd_exp))
    else $error("read data wrong");
  a_jtag_state: assert property (
    o_jtag_disabled == fs[2]) else $error("jtag disable state wrong");
  a_global_out: assert property (
    age[1] |-> ((o_pin_out ^ $past(~od & lvl)) & $past(en)) == 32'h0)
    else $error("global pin level wrong");
  a_global_oe: assert property (
    age[1] |-> ((o_pin_oe ^ $past(exp_oe)) & $past(en)) == 32'h0)
    else $error("global pin enable wrong");
  a_pwm0_route: assert property (
    age[1] && !$past(en[17]) |-> o_pin_out[17] ==
    $past(fs[9] ? i_sync_out : i_timer_pwm0) && o_pin_oe[17] ==
    $past(fs[9] ? i_sync_oe : 1'b1)) else $error("pwm0 pin route wrong");
  a_rtc_out: assert property (
    age[1] && $past(fs[0] && !en[27]) |-> o_pin_oe[27] &&
    o_pin_out[27] == $past(i_rtc_ref_clk)) else $error("rtc out wrong");
  a_spi_quiet: assert property (
    s_js_off2 |-> o_spi_in == 4'h0) else $error("spi lanes not quiet");
  a_jtag_idle: assert property (
    s_js_on2 |-> {o_jtag_tck, o_jtag_tms, o_jtag_tdi} == 3'b010)
    else $error("jtag lanes not idle");
endmodule
bind gio_pin_control gio_pin_control_chk #(.PINS(PINS)) i_chk (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_flash_checksum_ok(i_flash_checksum_ok), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe), .i_timer_pwm0(i_timer_pwm0),
  .i_sync_out(i_sync_out), .i_sync_oe(i_sync_oe), .o_jtag_tck(o_jtag_tck),
  .o_jtag_tms(o_jtag_tms), .o_jtag_tdi(o_jtag_tdi), .o_spi_in(o_spi_in),
  .i_rtc_ref_clk(i_rtc_ref_clk), .o_jtag_disabled(o_jtag_disabled));

/* bench/gio_pad_model.sv */
// Board-side model of the pads: outside drivers and pull-ups
`timescale 1ns/10ps
module gio_pad_model (
  input wire [31:0] i_dev_out,
  input wire [31:0] i_dev_oe,
  input wire [31:0] i_ext_en,
  input wire [31:0] i_ext_lvl,
  output logic [31:0] o_pad
);
  integer n;
  // A clash of unequal drivers reads unknown, so a fight is never hidden
  always @* begin
    for (n = 0; n < 32; n = n + 1) begin
      if (i_dev_oe[n] && i_ext_en[n])
        o_pad[n] = (i_dev_out[n] == i_ext_lvl[n]) ? i_ext_lvl[n] : 1'bx;
      else if (i_dev_oe[n])
        o_pad[n] = i_dev_out[n];
      else if (i_ext_en[n])
        o_pad[n] = i_ext_lvl[n];
      else
        o_pad[n] = 1'b1; // Released line floats up
    end
  end
endmodule

/* bench/gio_pin_control_tb_top.sv */
// Self-checking bench for the global I/O pin control block
`timescale 1ns/10ps
`include "gio_consts.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module gio_pin_control_tb_top;
  logic i_ref_clk = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, ok = 0;
  logic [31:0] i_addr = 0, i_wdata = 0, rdata, pad, pout, poe, fin, e_pad;
  logic [31:0] fout = 0, foe = 0, ext_en = 0, ext_lvl = 0, e_out, e_oe;
  logic tpwm = 0, s_out = 0, s_oe = 0, cap_a, cap_b, tdo = 0, tdo_oe = 0;
  logic [3:0] spi_out = 0, spi_oe = 0, spi_in;
  logic xtal = 0, rclk = 0, rtc_src, js, tck, tms, tdi;
  int err_total = 0, check_count = 0, k;
  int cpin[8] = '{19, 24, 26, 16, 16, 24, 26, 19};
  initial forever #25 i_ref_clk = ~i_ref_clk;
  gio_pin_control i_gio_pin_control (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .i_flash_checksum_ok(ok), .i_pin_in(pad), .o_pin_out(pout),
    .o_pin_oe(poe), .i_func_out(fout), .i_func_oe(foe), .o_func_in(fin),
    .i_timer_pwm0(tpwm), .i_sync_out(s_out), .i_sync_oe(s_oe),
    .o_capture_a(cap_a), .o_capture_b(cap_b), .i_jtag_tdo(tdo),
    .i_jtag_tdo_oe(tdo_oe), .o_jtag_tck(tck), .o_jtag_tms(tms),
    .o_jtag_tdi(tdi), .i_spi_out(spi_out), .i_spi_oe(spi_oe),
    .o_spi_in(spi_in), .i_crystal_clock_input(xtal), .i_rtc_ref_clk(rclk),
    .o_rtc_clk_src(rtc_src), .o_jtag_disabled(js));
  gio_pad_model i_gio_pad_model (.i_dev_out(pout), .i_dev_oe(poe),
    .i_ext_en(ext_en), .i_ext_lvl(ext_lvl), .o_pad(pad));
  // ----------------------------------------------------------------
  // Bus and sequencing tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // Idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input [31:0] a, input [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    step(1);
  endtask
  task automatic rd(input [31:0] a, input [31:0] e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 `CHK(rdata, e)
    step(1);
  endtask
  task automatic rst(input logic c);
    i_arst_n <= 1'b0;
    ok <= c;
    step(6);
    i_arst_n <= 1'b1;
    step(2);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog sized well past the roughly 280 cycles of the tests
  initial begin
    step(6000);
    err_total++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    step(1);
    rst(1'b0);
    rd(`GIO_ADDR_FUNC_SEL, 32'h0);
    for (k = 0; k < 4; k++) rd(`GIO_ADDR_ENABLE + 4 * k, 32'h0);
    rd(32'hfff7f02c, 32'h0);
    rst(1'b1);
    `CHK(js, 1'b1)
    rd(`GIO_ADDR_FUNC_SEL, 32'h4);
    wr(`GIO_ADDR_FUNC_SEL, 32'h10c);
    rd(`GIO_ADDR_FUNC_SEL, 32'h4);
    $display("reset test done");
    // Mixed push-pull and open-drain pins under global ownership
    wr(`GIO_ADDR_OPEN_DRAIN, 32'h00ff00ff);
    wr(`GIO_ADDR_LEVEL, 32'h5555aaaa);
    wr(`GIO_ADDR_DIR, 32'h0f0f0f0f);
    wr(`GIO_ADDR_ENABLE, 32'hffffffff);
    step(2);
    e_out = ~32'h00ff00ff & 32'h5555aaaa;
    e_oe = (32'h00ff00ff & 32'h5555aaaa) | (~32'h00ff00ff & 32'h0f0f0f0f);
    `CHK(pout, e_out)
    `CHK(poe, e_oe)
    ext_en <= ~e_oe & 32'hf0f0f0f0;
    ext_lvl <= 32'h3c3c3c3c;
    step(8);
    // Functional blocks see the same filtered pad levels as the readback
    e_pad = (e_oe & e_out) | (~e_oe & ~ext_en) | (ext_en & ext_lvl);
    rd(`GIO_ADDR_READBACK, e_pad);
    `CHK(fin, e_pad)
    rd(`GIO_ADDR_OPEN_DRAIN, 32'h00ff00ff);
    // Handing pins back to their functional drivers
    wr(`GIO_ADDR_ENABLE, 32'h0);
    ext_en <= 32'h0;
    fout <= 32'ha5a5a5a5;
    foe <= 32'h0ff0f00f;
    step(3);
    `CHK(pout & 32'hf0fdffff, 32'ha5a5a5a5 & 32'hf0fdffff)
    `CHK(poe & 32'hf0fdffff, 32'h0ff0f00f & 32'hf0fdffff)
    $display("global test done");
    foe <= 32'h0;
    tpwm <= 1'b1;
    for (k = 0; k < 2; k++) begin
      wr(`GIO_ADDR_FUNC_SEL, k ? 32'h200 : 32'h0);
      step(2);
      `CHK({pout[17], poe[17]}, {2{k == 0}})
    end
    $display("pwm0 test done");
    // Only the selected source pin carries the level being looked for
    ext_en <= ~32'h00020000;
    for (k = 0; k < 8; k++) begin
      wr(`GIO_ADDR_FUNC_SEL, (k % 4) << (k < 4 ? 4 : 6));
      ext_lvl <= 32'h1 << cpin[k];
      step(8);
      `CHK(k < 4 ? cap_a : cap_b, 1'b1)
      ext_lvl <= ~(32'h1 << cpin[k]);
      step(8);
      `CHK(k < 4 ? cap_a : cap_b, 1'b0)
    end
    $display("capture test done");
    wr(`GIO_ADDR_FUNC_SEL, 32'h0);
    ext_en <= ~32'h04020000;
    ext_lvl <= 32'h09000000;
    tdo <= 1'b1;
    tdo_oe <= 1'b1;
    step(8);
    `CHK({tck, tms, tdi}, 3'b101)
    `CHK({spi_in, pout[26], poe[26]}, 6'h03)
    tdo_oe <= 1'b0;
    spi_out <= 4'h8;
    spi_oe <= 4'h8;
    wr(`GIO_ADDR_FUNC_SEL, 32'h4);
    step(8);
    `CHK({spi_in, tck, tms, tdi}, 7'h6a)
    $display("test port test done");
    spi_oe <= 4'h0;
    for (k = 0; k < 2; k++) begin
      wr(`GIO_ADDR_FUNC_SEL, k ? 32'h2 : 32'h0);
      ext_lvl <= 32'h08000000;
      xtal <= 1'b0;
      step(8);
      `CHK(rtc_src, k == 1)
      ext_lvl <= 32'h0;
      xtal <= 1'b1;
      step(8);
      `CHK(rtc_src, k == 0)
    end
    ext_en <= ~32'h0c020000;
    wr(`GIO_ADDR_FUNC_SEL, 32'h1);
    rclk <= 1'b1;
    step(2);
    `CHK({pout[27], poe[27]}, 2'b11)
    rclk <= 1'b0;
    step(2);
    `CHK({pout[27], poe[27]}, 2'b01)
    $display("rtc test done");
    conclude();
  end
endmodule
